// [hw/mrm_cfg.svh]
// Purpose: constants of the meter serial slave
// Assumes: included by bare name, once per unit
// Notes: offsets are register word addresses on the line
`ifndef MRM_CFG_SVH
`define MRM_CFG_SVH
// ****************************************
// timing
// ****************************************
`define MRM_CLK_HZ 10000000
`define MRM_B1200 1200
`define MRM_B2400 2400
`define MRM_B4800 4800
`define MRM_B9600 9600
// silence of about three and a half characters, in bit times
`define MRM_GAP_BITS 6'h26
`define MRM_LAST_BIT 4'h7
// ****************************************
// configuration word layout and values
// ****************************************
`define MRM_ADR_HI 15
`define MRM_ADR_LO 8
`define MRM_FMT_HI 7
`define MRM_FMT_LO 6
`define MRM_BAUD_HI 3
`define MRM_BAUD_LO 0
`define MRM_BAUD_1200 4'h3
`define MRM_BAUD_2400 4'h4
`define MRM_BAUD_4800 4'h5
`define MRM_BAUD_9600 4'h6
`define MRM_FMT_E1 2'h1
`define MRM_FMT_O1 2'h2
`define MRM_FMT_N2 2'h3
`define MRM_CFG_RST 16'h0105
`define MRM_BCAST 8'h00
// ****************************************
// register map and fixed contents
// ****************************************
`define MRM_REG_MODEL_A 16'h0000
`define MRM_REG_MODEL_B 16'h0001
`define MRM_REG_VRANGE 16'h0002
`define MRM_REG_IRANGE 16'h0003
`define MRM_REG_CFG 16'h0004
`define MRM_REG_VOLT 16'h0048
`define MRM_REG_CURR 16'h0049
`define MRM_REG_POWER 16'h004A
`define MRM_REG_FWD_HI 16'h004B
`define MRM_REG_FWD_LO 16'h004C
`define MRM_REG_PF 16'h004D
`define MRM_REG_REV_HI 16'h004E
`define MRM_REG_REV_LO 16'h004F
`define MRM_REG_DIR 16'h0050
`define MRM_REG_FREQ 16'h0051
// model codes: arbitrary neutral values
`define MRM_MODEL_A 16'h1A2B
`define MRM_MODEL_B 16'h3C4D
`define MRM_VRANGE 16'h00FA
`define MRM_IRANGE 16'h0032
// ****************************************
// framing
// ****************************************
`define MRM_FC_RD 8'h03
`define MRM_FC_WR 8'h10
`define MRM_FC_RLY_RD 8'h01
`define MRM_FC_RLY_WR 8'h05
`define MRM_CRC_INIT 16'hFFFF
`define MRM_CRC_POLY 16'hA001
`define MRM_RD_LEN 8'h08
`define MRM_WR_LEN 8'h0B
`define MRM_WR_RSP_LEN 8'h08
`define MRM_RD_HDR 8'h03
`define MRM_CRC_LEN 8'h02
`define MRM_LEN_MAX 8'hFF
`define MRM_WR_BYTES 8'h02
`define MRM_IX_ADDR 8'h00
`define MRM_IX_FUNC 8'h01
`define MRM_IX_ST_HI 8'h02
`define MRM_IX_ST_LO 8'h03
`define MRM_IX_CNT_HI 8'h04
`define MRM_IX_CNT_LO 8'h05
`define MRM_IX_BCNT 8'h06
`define MRM_IX_WD_HI 8'h07
`define MRM_IX_WD_LO 8'h08
`define MRM_IX_RBCNT 8'h02
`endif

// [hw/mrm_pkg.sv]
// Purpose: types of the meter serial slave
// Assumes: nothing
// Notes: whole module state is one packed struct
package mrm_pkg;
    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_START = 3'b001,
        RX_DATA = 3'b010,
        RX_PAR = 3'b011,
        RX_STOP = 3'b100
    } mrm_rx_e;
    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_START = 3'b001,
        TX_DATA = 3'b010,
        TX_PAR = 3'b011,
        TX_STOP = 3'b100
    } mrm_tx_e;
    typedef enum logic {
        CTL_RECV = 1'b0,
        CTL_SEND = 1'b1
    } mrm_ctl_e;
    typedef struct packed {
        logic rx_s1;
        logic rx_s2;
        mrm_rx_e rx_st;
        logic [13:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_par;
        logic rx_err;
        logic [5:0] gap;
        logic [7:0] len;
        logic [15:0] crc;
        logic [7:0] addr;
        logic [7:0] func;
        logic [15:0] start;
        logic [15:0] count;
        logic [7:0] bcnt;
        logic [15:0] wdata;
        mrm_ctl_e ctl;
        mrm_tx_e tx_st;
        logic [13:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [7:0] tx_sh;
        logic tx_par;
        logic [7:0] tx_idx;
        logic [7:0] tx_len;
        logic [15:0] tx_crc;
        logic [15:0] cfg;
        logic [15:0] cfg_pend;
        logic [31:0] fwd_snap;
        logic [31:0] rev_snap;
        logic tx;
        logic oe_n;
    } mrm_state_s;
endpackage

// [hw/mrm_slave.sv]
// Purpose: serial RTU slave front end of a single-phase energy meter
// Assumes: measurement inputs are on core_clk_in; rx_in is asynchronous
// Notes: only function 03H reads and a one-word 10H write of 0004H are served
`timescale 1ns/100ps
`include "mrm_cfg.svh"

module mrm_slave #(
    parameter int CLK_HZ = `MRM_CLK_HZ
) (
    // clock and reset
    input logic core_clk_in,
    input logic srst_in,
    // serial line
    input logic rx_in,
    output logic tx_out,
    output logic line_oe_n_out,
    // configuration in force
    output logic [15:0] cfg_word_out,
    // measurement values
    input logic [15:0] volt_in,
    input logic [15:0] curr_in,
    input logic [15:0] power_in,
    input logic [31:0] fwd_energy_in,
    input logic [15:0] pf_in,
    input logic [31:0] rev_energy_in,
    input logic dir_neg_in,
    input logic [15:0] freq_in
);
    // ****************************************
    // state and helpers
    // ****************************************
    mrm_pkg::mrm_state_s q;
    mrm_pkg::mrm_state_s n;
    logic [13:0] bclk;
    logic [1:0] fmt;
    logic fmt_par;
    logic byte_go;
    logic frame_bad;
    logic addressed;
    logic rd_ok;
    logic wr_ok;
    logic eval_go;
    logic crc_bad_go;
    logic addr_miss_go;
    logic range_bad_go;
    logic reply_go;
    logic [7:0] tx_k;
    logic [15:0] tx_reg;
    logic [7:0] tx_byte;

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `MRM_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    function automatic logic [13:0] bit_clks(input logic [3:0] code);
        int hz;
        hz = CLK_HZ / `MRM_B4800;
        case (code)
            `MRM_BAUD_1200: hz = CLK_HZ / `MRM_B1200;
            `MRM_BAUD_2400: hz = CLK_HZ / `MRM_B2400;
            `MRM_BAUD_9600: hz = CLK_HZ / `MRM_B9600;
            default: hz = CLK_HZ / `MRM_B4800;
        endcase
        return 14'(hz - 1);
    endfunction

    function automatic logic range_ok(input logic [15:0] s, input logic [15:0] c);
        logic [16:0] last;
        last = {1'b0, s} + {1'b0, c} - 17'h00001;
        return (c != 16'h0000) && ((last <= {1'b0, `MRM_REG_CFG}) ||
            ((s >= `MRM_REG_VOLT) && (last <= {1'b0, `MRM_REG_FREQ})));
    endfunction

    function automatic logic cfg_ok(input logic [15:0] w);
        logic [3:0] b;
        b = w[`MRM_BAUD_HI:`MRM_BAUD_LO];
        return (w[`MRM_ADR_HI:`MRM_ADR_LO] != `MRM_BCAST) &&
            (b >= `MRM_BAUD_1200) && (b <= `MRM_BAUD_9600);
    endfunction

    function automatic logic [15:0] reg_val(input logic [15:0] a);
        case (a)
            `MRM_REG_MODEL_A: reg_val = `MRM_MODEL_A;
            `MRM_REG_MODEL_B: reg_val = `MRM_MODEL_B;
            `MRM_REG_VRANGE: reg_val = `MRM_VRANGE;
            `MRM_REG_IRANGE: reg_val = `MRM_IRANGE;
            `MRM_REG_CFG: reg_val = q.cfg;
            `MRM_REG_VOLT: reg_val = volt_in;
            `MRM_REG_CURR: reg_val = curr_in;
            `MRM_REG_POWER: reg_val = power_in;
            `MRM_REG_FWD_HI: reg_val = q.fwd_snap[31:16];
            `MRM_REG_FWD_LO: reg_val = q.fwd_snap[15:0];
            `MRM_REG_PF: reg_val = pf_in;
            `MRM_REG_REV_HI: reg_val = q.rev_snap[31:16];
            `MRM_REG_REV_LO: reg_val = q.rev_snap[15:0];
            `MRM_REG_DIR: reg_val = {15'h0000, dir_neg_in};
            `MRM_REG_FREQ: reg_val = freq_in;
            default: reg_val = 16'h0000;
        endcase
    endfunction

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        n = q;
        byte_go = 1'b0;
        frame_bad = 1'b0;
        eval_go = 1'b0;
        crc_bad_go = 1'b0;
        addr_miss_go = 1'b0;
        range_bad_go = 1'b0;
        reply_go = 1'b0;
        bclk = bit_clks(q.cfg[`MRM_BAUD_HI:`MRM_BAUD_LO]);
        fmt = q.cfg[`MRM_FMT_HI:`MRM_FMT_LO];
        fmt_par = (fmt == `MRM_FMT_E1) || (fmt == `MRM_FMT_O1);
        addressed = (q.addr == q.cfg[`MRM_ADR_HI:`MRM_ADR_LO])
            || (q.addr == `MRM_BCAST);
        // relay codes are neither decoded nor served, so they stay silent
        rd_ok = (q.func == `MRM_FC_RD) && (q.len == `MRM_RD_LEN)
            && range_ok(q.start, q.count);
        wr_ok = (q.func == `MRM_FC_WR) && (q.len == `MRM_WR_LEN)
            && (q.start == `MRM_REG_CFG) && (q.count == 16'h0001)
            && (q.bcnt == `MRM_WR_BYTES) && cfg_ok(q.wdata);
        // reply byte for the current index
        tx_k = q.tx_idx - `MRM_RD_HDR;
        tx_reg = reg_val(q.start + {9'h000, tx_k[7:1]});
        tx_byte = tx_k[0] ? tx_reg[7:0] : tx_reg[15:8];
        if (q.func == `MRM_FC_WR) begin
            case (q.tx_idx)
                `MRM_IX_ST_HI: tx_byte = q.start[15:8];
                `MRM_IX_ST_LO: tx_byte = q.start[7:0];
                `MRM_IX_CNT_HI: tx_byte = q.count[15:8];
                `MRM_IX_CNT_LO: tx_byte = q.count[7:0];
                default: ;
            endcase
        end else if (q.tx_idx == `MRM_IX_RBCNT) begin
            tx_byte = {q.count[6:0], 1'b0};
        end
        if (q.tx_idx == `MRM_IX_ADDR) begin
            tx_byte = q.cfg[`MRM_ADR_HI:`MRM_ADR_LO];
        end
        if (q.tx_idx == `MRM_IX_FUNC) begin
            tx_byte = q.func;
        end
        if (q.tx_idx == q.tx_len - `MRM_CRC_LEN) begin
            tx_byte = q.tx_crc[7:0];
        end
        if (q.tx_idx == q.tx_len - 8'h01) begin
            tx_byte = q.tx_crc[15:8];
        end
        // ****************************************
        // receiver
        // ****************************************
        n.rx_s1 = rx_in;
        n.rx_s2 = q.rx_s1;
        n.rx_cnt = (q.rx_cnt == 14'h0000) ? bclk : q.rx_cnt - 14'h0001;
        unique case (q.rx_st)
            mrm_pkg::RX_IDLE: begin
                if (!q.rx_s2) begin
                    n.rx_st = mrm_pkg::RX_START;
                    n.rx_cnt = bclk >> 1;
                    n.gap = 6'h00;
                end else if ((q.rx_cnt == 14'h0000) && (q.gap != `MRM_GAP_BITS)) begin
                    n.gap = q.gap + 6'h01;
                end
            end
            mrm_pkg::RX_START: begin
                if (q.rx_cnt == 14'h0000) begin
                    // a glitch shorter than half a bit is dropped
                    n.rx_st = q.rx_s2 ? mrm_pkg::RX_IDLE : mrm_pkg::RX_DATA;
                    n.rx_bit = 4'h0;
                    n.rx_par = 1'b0;
                end
            end
            mrm_pkg::RX_DATA: begin
                if (q.rx_cnt == 14'h0000) begin
                    n.rx_sh = {q.rx_s2, q.rx_sh[7:1]};
                    n.rx_par = q.rx_par ^ q.rx_s2;
                    n.rx_bit = q.rx_bit + 4'h1;
                    if (q.rx_bit == `MRM_LAST_BIT) begin
                        n.rx_st = fmt_par ? mrm_pkg::RX_PAR : mrm_pkg::RX_STOP;
                    end
                end
            end
            mrm_pkg::RX_PAR: begin
                if (q.rx_cnt == 14'h0000) begin
                    frame_bad = (q.rx_par ^ q.rx_s2) != (fmt == `MRM_FMT_O1);
                    n.rx_st = mrm_pkg::RX_STOP;
                end
            end
            mrm_pkg::RX_STOP: begin
                if (q.rx_cnt == 14'h0000) begin
                    byte_go = 1'b1;
                    frame_bad = !q.rx_s2;
                    n.rx_st = mrm_pkg::RX_IDLE;
                    n.gap = 6'h00;
                end
            end
        endcase
        // ****************************************
        // request assembly and check
        // ****************************************
        if (q.ctl == mrm_pkg::CTL_RECV) begin
            if (frame_bad) begin
                n.rx_err = 1'b1;
            end
            if (byte_go) begin
                n.crc = crc_byte(q.crc, q.rx_sh);
                if (q.len != `MRM_LEN_MAX) begin
                    n.len = q.len + 8'h01;
                end
                case (q.len)
                    `MRM_IX_ADDR: n.addr = q.rx_sh;
                    `MRM_IX_FUNC: n.func = q.rx_sh;
                    `MRM_IX_ST_HI: n.start[15:8] = q.rx_sh;
                    `MRM_IX_ST_LO: n.start[7:0] = q.rx_sh;
                    `MRM_IX_CNT_HI: n.count[15:8] = q.rx_sh;
                    `MRM_IX_CNT_LO: n.count[7:0] = q.rx_sh;
                    `MRM_IX_BCNT: n.bcnt = q.rx_sh;
                    `MRM_IX_WD_HI: n.wdata[15:8] = q.rx_sh;
                    `MRM_IX_WD_LO: n.wdata[7:0] = q.rx_sh;
                    default: ;
                endcase
            end
            if ((q.gap == `MRM_GAP_BITS) && (q.len != 8'h00) && !byte_go) begin
                eval_go = 1'b1;
                n.len = 8'h00;
                n.crc = `MRM_CRC_INIT;
                n.rx_err = 1'b0;
                // a frame with its own CRC appended leaves a zero remainder
                crc_bad_go = q.crc != 16'h0000;
                addr_miss_go = !addressed;
                range_bad_go = (q.func == `MRM_FC_RD) && !rd_ok;
                if (!q.rx_err && !crc_bad_go && addressed && (rd_ok || wr_ok)) begin
                    n.fwd_snap = fwd_energy_in;
                    n.rev_snap = rev_energy_in;
                    n.cfg_pend = wr_ok ? q.wdata : q.cfg;
                    if (q.addr == `MRM_BCAST) begin
                        n.cfg = n.cfg_pend;
                    end else begin
                        reply_go = 1'b1;
                        n.ctl = mrm_pkg::CTL_SEND;
                        n.oe_n = 1'b0;
                        n.tx_idx = 8'h00;
                        n.tx_crc = `MRM_CRC_INIT;
                        n.tx_len = rd_ok ? `MRM_RD_HDR + {q.count[6:0], 1'b0} + `MRM_CRC_LEN
                            : `MRM_WR_RSP_LEN;
                    end
                end
            end
        end
        // ****************************************
        // transmitter
        // ****************************************
        n.tx_cnt = (q.tx_cnt == 14'h0000) ? bclk : q.tx_cnt - 14'h0001;
        unique case (q.tx_st)
            mrm_pkg::TX_IDLE: begin
                if (q.ctl == mrm_pkg::CTL_SEND) begin
                    if (q.tx_idx != q.tx_len) begin
                        n.tx_sh = tx_byte;
                        n.tx_par = (^tx_byte) ^ (fmt == `MRM_FMT_O1);
                        if (q.tx_idx < q.tx_len - `MRM_CRC_LEN) begin
                            n.tx_crc = crc_byte(q.tx_crc, tx_byte);
                        end
                        n.tx_idx = q.tx_idx + 8'h01;
                        n.tx_st = mrm_pkg::TX_START;
                        n.tx_cnt = bclk;
                        n.tx = 1'b0;
                    end else begin
                        // new settings of an answered write take effect only once the answer is out
                        n.ctl = mrm_pkg::CTL_RECV;
                        n.oe_n = 1'b1;
                        n.cfg = q.cfg_pend;
                        n.gap = 6'h00;
                    end
                end
            end
            mrm_pkg::TX_START: begin
                if (q.tx_cnt == 14'h0000) begin
                    n.tx = q.tx_sh[0];
                    n.tx_sh = q.tx_sh >> 1;
                    n.tx_bit = 4'h0;
                    n.tx_st = mrm_pkg::TX_DATA;
                end
            end
            mrm_pkg::TX_DATA: begin
                if (q.tx_cnt == 14'h0000) begin
                    if (q.tx_bit != `MRM_LAST_BIT) begin
                        n.tx = q.tx_sh[0];
                        n.tx_sh = q.tx_sh >> 1;
                        n.tx_bit = q.tx_bit + 4'h1;
                    end else begin
                        n.tx = fmt_par ? q.tx_par : 1'b1;
                        n.tx_bit = 4'h0;
                        n.tx_st = fmt_par ? mrm_pkg::TX_PAR : mrm_pkg::TX_STOP;
                    end
                end
            end
            mrm_pkg::TX_PAR: begin
                if (q.tx_cnt == 14'h0000) begin
                    n.tx = 1'b1;
                    n.tx_st = mrm_pkg::TX_STOP;
                end
            end
            mrm_pkg::TX_STOP: begin
                if (q.tx_cnt == 14'h0000) begin
                    if ((fmt == `MRM_FMT_N2) && (q.tx_bit == 4'h0)) begin
                        n.tx_bit = 4'h1;
                    end else begin
                        n.tx_st = mrm_pkg::TX_IDLE;
                    end
                end
            end
        endcase
        if (srst_in) begin
            n = '0;
            n.rx_s1 = 1'b1;
            n.rx_s2 = 1'b1;
            n.crc = `MRM_CRC_INIT;
            n.cfg = `MRM_CFG_RST;
            n.cfg_pend = `MRM_CFG_RST;
            n.tx = 1'b1;
            n.oe_n = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        q <= n;
    end

    assign tx_out = q.tx;
    assign line_oe_n_out = q.oe_n;
    assign cfg_word_out = q.cfg;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (srst_in);

    sequence reply_open;
        $fell(line_oe_n_out);
    endsequence
    sequence stays_quiet;
        line_oe_n_out [*8];
    endsequence

    idle_line_high_a: assert property (line_oe_n_out |-> tx_out)
        else $error("line not idle high while released");
    reply_cause_a: assert property (reply_open |-> $past(reply_go))
        else $error("line driven without a valid query");
    start_bit_a: assert property (reply_open |-> ##[0:2] !tx_out)
        else $error("reply did not open with a start bit");
    bad_crc_quiet_a: assert property (crc_bad_go |=> stays_quiet)
        else $error("reply after CRC mismatch");
    addr_miss_quiet_a: assert property (addr_miss_go |=> stays_quiet)
        else $error("reply to another station");
    range_quiet_a: assert property (range_bad_go |=> stays_quiet)
        else $error("reply to out-of-range read");
    vrange_value_a: assert property (reg_val(`MRM_REG_VRANGE) == 16'h00FA)
        else $error("voltage range word wrong");
    irange_value_a: assert property (reg_val(`MRM_REG_IRANGE) == 16'h0032)
        else $error("current range word wrong");
    crc_step_a: assert property (crc_byte(`MRM_CRC_INIT, 8'h01) == 16'h807E)
        else $error("CRC step wrong");
    dir_word_a: assert property (reg_val(`MRM_REG_DIR) == {15'h0000, dir_neg_in})
        else $error("direction word wrong");
    energy_snap_a: assert property (reply_go |=> q.fwd_snap == $past(fwd_energy_in))
        else $error("energy not captured at the query");
endmodule

// [bench/mrm_host.sv]
// Purpose: host master model on the serial line
// Assumes: line idles high through a pull-up when nobody sends
// Notes: the bench sets bit time and format between frames
`timescale 1ns/100ps
module mrm_host (
    // clock
    input wire logic core_clk_in,
    // line from the slave
    input wire logic line_in,
    input wire logic oe_n_in,
    // line to the slave
    output logic rx_out
);
    int bt = 20;
    logic [1:0] fmt = 2'h0;
    logic [7:0] rq[$];
    logic [7:0] rs[$];
    initial rx_out = 1'b1;
    function automatic logic [15:0] crc16(input logic [7:0] q[$]);
        logic [15:0] c = 16'hFFFF;
        foreach (q[i]) begin
            c ^= {8'h00, q[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction
    task automatic put_byte(input logic [7:0] b);
        logic [10:0] fr;
        fr = {2'b11, fmt == 2'h1 ? ^b : (fmt == 2'h2 ? ~^b : 1'b1), b, 1'b0};
        for (int i = 0; i < (fmt == 2'h0 ? 10 : 11); i++) begin
            rx_out <= fr[i];
            repeat (bt) @(posedge core_clk_in);
        end
    endtask
    // one host, one address per query; a flipped crc bit makes a broken frame
    task automatic send(input logic bad);
        logic [15:0] c;
        @(posedge core_clk_in);
        c = crc16(rq) ^ {15'h0000, bad};
        rq = {rq, c[7:0], c[15:8]};
        foreach (rq[i]) put_byte(rq[i]);
    endtask
    // sampled on the falling edge so the slave's updates have landed
    task automatic get_reply();
        logic [7:0] b;
        int n = 0;
        rs = {};
        while (n < 60 * bt && !(oe_n_in && rs.size() > 0)) begin
            @(negedge core_clk_in);
            n++;
            if (!oe_n_in && !line_in) begin
                repeat (bt / 2) @(negedge core_clk_in);
                for (int i = 0; i < 8; i++) begin
                    repeat (bt) @(negedge core_clk_in);
                    b[i] = line_in;
                end
                rs.push_back(b);
                repeat (fmt inside {2'h1, 2'h2} ? 2 * bt : bt) @(negedge core_clk_in);
            end
        end
    endtask
endmodule

// [bench/tb_mrm_slave.sv]
// Purpose: self-checking bench of the meter serial slave
// Assumes: CLK_HZ shortened so bit times are 10 to 80 clocks
// Notes: bad frames must leave the line silent
`timescale 1ns/100ps
`include "mrm_cfg.svh"
module tb_mrm_slave;
    localparam int HZ = 96000;
    logic core_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic rx, tx, oe_n, dir = 1'b0;
    logic [15:0] cfg, volt = 16'h0000, curr = 16'h0000, power = 16'h0000;
    logic [15:0] pf = 16'h0000, freq = 16'h0000;
    logic [31:0] fwd = 32'h00000000, rev = 32'h00000000;
    logic [7:0] exp[$];
    logic [15:0] w[$];
    int err_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int seed = 32'h4EF8;
    always #50 core_clk_in = ~core_clk_in;
    mrm_slave #(.CLK_HZ(HZ)) dut (.core_clk_in(core_clk_in), .srst_in(srst_in), .rx_in(rx),
        .tx_out(tx), .line_oe_n_out(oe_n), .cfg_word_out(cfg), .volt_in(volt), .curr_in(curr),
        .power_in(power), .fwd_energy_in(fwd), .pf_in(pf), .rev_energy_in(rev),
        .dir_neg_in(dir), .freq_in(freq));
    mrm_host host (.core_clk_in(core_clk_in), .line_in(tx), .oe_n_in(oe_n), .rx_out(rx));
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask
    task automatic conclude();
        $display("checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic ask(input logic [7:0] a, f, input logic [15:0] s, n);
        host.rq = '{a, f, s[15:8], s[7:0], n[15:8], n[7:0]};
    endtask
    // mode 0: silence, 1: read reply of w, 2: echo of the write header
    task automatic xact(input int mode, input logic bad);
        logic [15:0] c;
        exp = {};
        if (mode == 1) exp = '{host.rq[0], host.rq[1], 8'(2 * w.size())};
        foreach (w[i]) if (mode == 1) exp = {exp, w[i][15:8], w[i][7:0]};
        if (mode == 2) exp = host.rq[0:5];
        c = host.crc16(exp);
        if (mode != 0) exp = {exp, c[7:0], c[15:8]};
        host.send(bad);
        host.get_reply();
        chk("reply length", 16'(exp.size()), 16'(host.rs.size()));
        foreach (exp[i]) if (i < host.rs.size()) chk("reply byte", exp[i], host.rs[i]);
    endtask
    always @(negedge core_clk_in) if (oe_n === 1'b1) chk("idle line", 16'h0001, tx);
    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        repeat (3) @(posedge core_clk_in);
        srst_in <= 1'b0;
        repeat (3) @(posedge core_clk_in);
        chk("config word", 16'h0105, cfg);
        ask(8'h01, `MRM_FC_RD, 16'h0000, 16'h0004);
        w = '{`MRM_MODEL_A, `MRM_MODEL_B, 16'h00FA, 16'h0032};
        xact(1, 1'b0);
        @(posedge core_clk_in);
        volt <= 16'($random(seed));
        curr <= 16'($random(seed));
        power <= 16'($random(seed));
        pf <= 16'($random(seed));
        freq <= 16'($random(seed));
        fwd <= $random(seed);
        rev <= $random(seed);
        dir <= 1'($random(seed));
        @(posedge core_clk_in);
        ask(8'h01, `MRM_FC_RD, 16'h0048, 16'h000A);
        w = '{volt, curr, power, fwd[31:16], fwd[15:0], pf, rev[31:16], rev[15:0],
            {15'h0000, dir}, freq};
        xact(1, 1'b0);
        // a fresh request so that only the flipped CRC bit makes it wrong
        ask(8'h01, `MRM_FC_RD, 16'h0048, 16'h000A);
        xact(0, 1'b1);
        ask(8'h07, `MRM_FC_RD, 16'h0000, 16'h0001);
        xact(0, 1'b0);
        ask(8'h01, `MRM_FC_RD, 16'h0050, 16'h0003);
        xact(0, 1'b0);
        ask(8'h01, `MRM_FC_RLY_RD, 16'h0000, 16'h0001);
        xact(0, 1'b0);
        ask(`MRM_BCAST, `MRM_FC_WR, `MRM_REG_CFG, 16'h0001);
        host.rq = {host.rq, 8'h02, 8'h02, 8'h86};
        xact(0, 1'b0);
        chk("config word", 16'h0286, cfg);
        host.bt = HZ / 9600;
        host.fmt = 2'h2;
        ask(8'h02, `MRM_FC_WR, `MRM_REG_CFG, 16'h0001);
        host.rq = {host.rq, 8'h02, 8'h03, 8'h46};
        xact(2, 1'b0);
        chk("config word", 16'h0346, cfg);
        // odd parity against an even-parity slave: every byte is a parity error
        ask(8'h03, `MRM_FC_RD, 16'h0002, 16'h0001);
        xact(0, 1'b0);
        host.fmt = 2'h1;
        ask(8'h03, `MRM_FC_RD, 16'h0000, 16'h0005);
        w = '{`MRM_MODEL_A, `MRM_MODEL_B, 16'h00FA, 16'h0032, 16'h0346};
        xact(1, 1'b0);
        ask(8'h03, `MRM_FC_WR, `MRM_REG_CFG, 16'h0001);
        host.rq = {host.rq, 8'h02, 8'h03, 8'hC3};
        xact(2, 1'b0);
        chk("config word", 16'h03C3, cfg);
        host.bt = HZ / 1200;
        host.fmt = 2'h3;
        ask(8'h03, `MRM_FC_RD, 16'h0002, 16'h0002);
        w = '{16'h00FA, 16'h0032};
        xact(1, 1'b0);
        conclude();
    end
endmodule
